/* pkg/front_panel_pkg.sv */
// Purpose: Shared constants and types for the front-panel selection controller.
// Assumes: 100 MHz system clock, buttons and encoder already debounced and synchronous.
// Notes:   Register offsets are byte addresses on the plain register port.
package front_panel_pkg;

  // Clock rate and the panel timing figures.
  localparam int unsigned CLK_MHZ          = 100;
  localparam int unsigned INACT_TIME_MS    = 5000;
  localparam int unsigned CHORD_TIME_MS    = 3000;
  localparam int unsigned INACT_CYCLES     = INACT_TIME_MS * CLK_MHZ * 1000;
  localparam int unsigned CHORD_CYCLES     = CHORD_TIME_MS * CLK_MHZ * 1000;

  // Geometry of the panel.
  localparam int unsigned NUM_MIX          = 4;
  localparam int unsigned NUM_PRESET       = 16;
  localparam int unsigned NUM_FRONT_PRESET = 4;
  localparam int unsigned METER_SEGS       = 15;

  // Register byte offsets.
  localparam logic [7:0] REG_STATUS     = 8'h00;
  localparam logic [7:0] REG_MASK       = 8'h04;
  localparam logic [7:0] REG_FX_PRESET  = 8'h08;
  localparam logic [7:0] REG_FX_RETURN  = 8'h0C;
  localparam logic [7:0] REG_SEL_STATE  = 8'h10;
  localparam logic [7:0] REG_HP_LEVEL   = 8'h14;

  // Status and mask bit positions.
  localparam int unsigned ST_REVERT   = 0;
  localparam int unsigned ST_FACTORY  = 1;
  localparam int unsigned ST_OVERLOAD = 2;
  localparam int unsigned ST_LEVEL    = 3;
  localparam int unsigned ST_W        = 4;

  // Selection state field positions.
  localparam int unsigned SS_MIX_LSB    = 0;
  localparam int unsigned SS_TGT_LSB    = 2;
  localparam int unsigned SS_CH_LSB     = 4;
  localparam int unsigned SS_IDLE_BIT   = 8;

  // Reset values.
  localparam logic [ST_W-1:0] MASK_RESET   = 4'h0;
  localparam logic [3:0]      PRESET_RESET = 4'h0;

  // Chosen mix.
  typedef enum logic [1:0] {
    MIX_MAIN           = 2'b00,
    MIX_MONITOR_SEND_1 = 2'b01,
    MIX_MONITOR_SEND_2 = 2'b10,
    MIX_EFFECTS_SEND   = 2'b11
  } mix_t;

  // What the encoder currently adjusts.
  typedef enum logic [1:0] {
    TGT_OUTPUT    = 2'b00,
    TGT_CHANNEL   = 2'b01,
    TGT_HEADPHONE = 2'b10
  } target_t;

  // Panel buttons other than the channel row.
  typedef struct packed {
    logic mix_sel;
    logic out_sel;
    logic effect;
    logic headphone;
  } btn_t;

  // One encoder detent: a step pulse and its direction.
  typedef struct packed {
    logic step;
    logic cw;
  } enc_t;

endpackage

/* design/front_panel_select_ctrl.sv */
// Purpose: Front-panel selection, level control, meter and preset logic of a small mixer.
// Assumes: Buttons are clean synchronous levels, encoder gives one-cycle step pulses.
// Notes:   Levels live in flip-flop arrays; the audio path reads them on level ports.
// Operation
// [R1] Encoder steps raise (clockwise) or lower the currently selected level.
// [R2] Power up on main output; revert to main after five idle seconds.
// [R3] Output-select picks the chosen mix's output level and lights white.
// [R4] Mix-select steps main, send 1, send 2, effects send; chosen mix lit.
// [R5] A channel button picks that channel's level into the chosen mix.
// [R6] While adjusting, the meter shows the selected level in white.
// [R7] Effect button steps four front presets; the chosen one lights white.
// [R8] Sixteen presets and effect return level; extra ones set by software only.
// [R9] Headphone button picks the headphone level and lights it white.
// [R10] Holding channel 1, channel 2 and output-select restores factory levels.
// [R11] A factory reset also clears the paired-device list.
// [R12] After five idle seconds the meter shows the main meter in green.
// [R13] A channel indicator lights red while that channel overloads.
// [R14] Any press or step restarts the timer; reverting clears old selections.
// [R15] The smaller model skips the second monitor send when stepping mixes.
//
// The address map and the strobed register port were decided locally.
`timescale 1ns/1ps
module front_panel_select_ctrl
  import front_panel_pkg::*;
#(
  parameter int unsigned NUM_CH        = 6,
  parameter bit          LARGE_MODEL   = 1'b1,
  parameter int unsigned LEVEL_W       = 8,
  parameter int unsigned INACT_COUNT   = front_panel_pkg::INACT_CYCLES,
  parameter int unsigned CHORD_COUNT   = front_panel_pkg::CHORD_CYCLES
) (
  // Clock and reset.
  input  wire logic                           clk,
  input  wire logic                           arst_n,
  // Operator controls.
  input  wire front_panel_pkg::btn_t          btn,
  input  wire logic [NUM_CH-1:0]              btn_ch,
  input  wire front_panel_pkg::enc_t          enc,
  // Audio side status.
  input  wire logic [NUM_CH-1:0]              ch_overload,
  input  wire logic [LEVEL_W-1:0]             main_meter,
  // Register port.
  input  wire logic [7:0]                     reg_addr,
  input  wire logic [31:0]                    reg_wdata,
  input  wire logic                           reg_wr,
  input  wire logic                           reg_rd,
  output logic      [31:0]                    reg_rdata,
  output logic                                irq,
  // Indicators.
  output logic      [NUM_MIX-1:0]             led_mix_white,
  output logic                                led_out_white,
  output logic      [NUM_CH-1:0]              led_ch_white,
  output logic      [NUM_CH-1:0]              led_ch_red,
  output logic      [NUM_FRONT_PRESET-1:0]    led_fx_white,
  output logic                                led_hp_white,
  output logic      [METER_SEGS-1:0]          meter_white,
  output logic      [METER_SEGS-1:0]          meter_green,
  // Mixer parameters.
  output logic      [NUM_MIX*NUM_CH*LEVEL_W-1:0] ch_levels,
  output logic      [NUM_MIX*LEVEL_W-1:0]     out_levels,
  output logic      [LEVEL_W-1:0]             hp_level,
  output logic      [3:0]                     fx_preset,
  output logic      [LEVEL_W-1:0]             fx_return,
  output logic                                pair_clear
);

  import front_panel_pkg::*;

  localparam int unsigned CH_W = (NUM_CH > 1) ? $clog2(NUM_CH) : 1;

  // Saturating one-step level change.
  function automatic logic [LEVEL_W-1:0] adj(input logic [LEVEL_W-1:0] l, input logic up);
    if (up) begin
      adj = (&l) ? l : l + 1'b1;
    end else begin
      adj = (l == '0) ? l : l - 1'b1;
    end
  endfunction

  // Level to a thermometer bar, full scale lights every segment.
  function automatic logic [METER_SEGS-1:0] bar(input logic [LEVEL_W-1:0] l);
    logic [LEVEL_W+3:0] s;
    logic [3:0]         n;
    s = (LEVEL_W+4)'(l) * (LEVEL_W+4)'(METER_SEGS) + (LEVEL_W+4)'({LEVEL_W{1'b1}});
    n = s[LEVEL_W+3:LEVEL_W];
    for (int i = 0; i < METER_SEGS; i++) begin
      bar[i] = (4'(i) < n);
    end
  endfunction

  // Next mix in the rotation; the small model has no second monitor send.
  function automatic mix_t next_mix(input mix_t m);
    case (m)
      MIX_MAIN:           next_mix = MIX_MONITOR_SEND_1;
      MIX_MONITOR_SEND_1: next_mix = LARGE_MODEL ? MIX_MONITOR_SEND_2 : MIX_EFFECTS_SEND; // [R15]
      MIX_MONITOR_SEND_2: next_mix = MIX_EFFECTS_SEND;
      default:            next_mix = MIX_MAIN;
    endcase
  endfunction

  logic [LEVEL_W-1:0] ch_lvl_q [NUM_MIX][NUM_CH];
  logic [LEVEL_W-1:0] out_lvl_q [NUM_MIX];
  logic [LEVEL_W-1:0] hp_q;
  logic [LEVEL_W-1:0] fx_ret_q;
  logic [3:0]         preset_q;
  mix_t               mix_q;
  target_t            tgt_q;
  logic [CH_W-1:0]    ch_sel_q;
  btn_t               btn_q;
  logic [NUM_CH-1:0]  btn_ch_q;
  logic [31:0]        idle_cnt_q;
  logic               idle_q;
  logic [31:0]        chord_cnt_q;
  logic               chord_done_q;
  logic               factory_q;
  logic [ST_W-1:0]    status_q;
  logic [ST_W-1:0]    mask_q;
  logic [NUM_CH-1:0]  ovl_q;

  // Press detection on rising button levels.
  btn_t              press;
  logic [NUM_CH-1:0] ch_press;
  logic              activity;
  logic              ch_any;
  logic [CH_W-1:0]   ch_first;
  logic              revert;
  logic              chord;
  assign press    = btn & ~btn_q;
  assign ch_press = btn_ch & ~btn_ch_q;
  assign activity = (|press) | (|ch_press) | enc.step; // [R14]
  assign chord    = btn_ch[0] & btn_ch[(NUM_CH > 1) ? 1 : 0] & btn.out_sel;
  assign revert   = (idle_cnt_q == 32'(INACT_COUNT - 1)) && !activity;

  // Lowest pressed channel wins when several go down together.
  always_comb begin
    ch_any   = 1'b0;
    ch_first = '0;
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (ch_press[i]) begin
        ch_any   = 1'b1;
        ch_first = CH_W'(i);
      end
    end
  end

  // Button history for edge detection.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      btn_q    <= '0;
      btn_ch_q <= '0;
      ovl_q    <= '0;
    end else begin
      btn_q    <= btn;
      btn_ch_q <= btn_ch;
      ovl_q    <= ch_overload;
    end
  end

  // Inactivity timer; it saturates so the idle state holds indefinitely.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      idle_cnt_q <= 32'(INACT_COUNT - 1);
      idle_q     <= 1'b1;
    end else if (activity) begin
      idle_cnt_q <= '0; // [R14]
      idle_q     <= 1'b0;
    end else if (idle_cnt_q != 32'(INACT_COUNT - 1)) begin
      idle_cnt_q <= idle_cnt_q + 32'd1;
    end else begin
      idle_q     <= 1'b1; // [R12]
    end
  end

  // Selection state: chosen mix, adjustment target and channel.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mix_q    <= MIX_MAIN; // [R2]
      tgt_q    <= TGT_OUTPUT;
      ch_sel_q <= '0;
    end else if (revert || factory_q) begin
      mix_q    <= MIX_MAIN; // [R2]
      tgt_q    <= TGT_OUTPUT; // [R14]
      ch_sel_q <= '0;
    end else if (press.mix_sel) begin
      mix_q    <= next_mix(mix_q); // [R4]
      tgt_q    <= TGT_OUTPUT;
    end else if (press.out_sel) begin
      tgt_q    <= TGT_OUTPUT; // [R3] [R5]
    end else if (ch_any) begin
      tgt_q    <= TGT_CHANNEL; // [R5]
      ch_sel_q <= ch_first;
    end else if (press.headphone) begin
      tgt_q    <= TGT_HEADPHONE; // [R9]
    end
  end

  // Factory-reset chord must be held; it fires once per hold.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      chord_cnt_q  <= '0;
      chord_done_q <= 1'b0;
      factory_q    <= 1'b0;
    end else begin
      factory_q <= 1'b0;
      if (!chord) begin
        chord_cnt_q  <= '0;
        chord_done_q <= 1'b0;
      end else if (!chord_done_q) begin
        if (chord_cnt_q == 32'(CHORD_COUNT - 1)) begin
          factory_q    <= 1'b1; // [R10]
          chord_done_q <= 1'b1;
        end else begin
          chord_cnt_q <= chord_cnt_q + 32'd1;
        end
      end
    end
  end

  // Level store; a factory reset wipes every level at once.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int m = 0; m < NUM_MIX; m++) begin
        out_lvl_q[m] <= '0;
        for (int c = 0; c < NUM_CH; c++) begin
          ch_lvl_q[m][c] <= '0;
        end
      end
      hp_q <= '0;
    end else if (factory_q) begin
      for (int m = 0; m < NUM_MIX; m++) begin
        out_lvl_q[m] <= '0; // [R10]
        for (int c = 0; c < NUM_CH; c++) begin
          ch_lvl_q[m][c] <= '0;
        end
      end
      hp_q <= '0;
    end else if (enc.step) begin
      case (tgt_q)
        TGT_CHANNEL:   ch_lvl_q[mix_q][ch_sel_q] <= adj(ch_lvl_q[mix_q][ch_sel_q], enc.cw); // [R1]
        TGT_HEADPHONE: hp_q <= adj(hp_q, enc.cw); // [R1] [R9]
        default:       out_lvl_q[mix_q] <= adj(out_lvl_q[mix_q], enc.cw); // [R1]
      endcase
    end
  end

  // Effect preset and return level; software may pick any of the sixteen.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      preset_q <= PRESET_RESET;
      fx_ret_q <= '0;
    end else if (factory_q) begin
      preset_q <= PRESET_RESET;
      fx_ret_q <= '0;
    end else if (press.effect) begin
      // A software preset outside the front four restarts the front cycle.
      preset_q <= (preset_q >= 4'(NUM_FRONT_PRESET - 1)) ? 4'h0 : preset_q + 4'h1; // [R7]
    end else if (reg_wr && reg_addr == REG_FX_PRESET) begin
      preset_q <= reg_wdata[3:0]; // [R8]
    end else if (reg_wr && reg_addr == REG_FX_RETURN) begin
      fx_ret_q <= reg_wdata[LEVEL_W-1:0]; // [R8]
    end
  end

  // Sticky status, write one to clear; a new event beats a same-cycle clear.
  logic [ST_W-1:0] events;
  always_comb begin
    events              = '0;
    events[ST_REVERT]   = revert && !(mix_q == MIX_MAIN && tgt_q == TGT_OUTPUT);
    events[ST_FACTORY]  = factory_q;
    events[ST_OVERLOAD] = |(ch_overload & ~ovl_q);
    events[ST_LEVEL]    = enc.step;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      status_q <= '0;
      mask_q   <= MASK_RESET;
    end else begin
      if (reg_wr && reg_addr == REG_STATUS) begin
        status_q <= (status_q & ~reg_wdata[ST_W-1:0]) | events;
      end else begin
        status_q <= status_q | events;
      end
      if (reg_wr && reg_addr == REG_MASK) begin
        mask_q <= reg_wdata[ST_W-1:0];
      end
    end
  end

  assign irq = |(status_q & mask_q);

  // Read data one cycle after the strobe; unmapped offsets read zero.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      reg_rdata <= '0;
      case (reg_addr)
        REG_STATUS:    reg_rdata[ST_W-1:0]    <= status_q;
        REG_MASK:      reg_rdata[ST_W-1:0]    <= mask_q;
        REG_FX_PRESET: reg_rdata[3:0]         <= preset_q;
        REG_FX_RETURN: reg_rdata[LEVEL_W-1:0] <= fx_ret_q;
        REG_SEL_STATE: begin
          reg_rdata[SS_MIX_LSB +: 2]    <= mix_q;
          reg_rdata[SS_TGT_LSB +: 2]    <= tgt_q;
          reg_rdata[SS_CH_LSB +: CH_W]  <= ch_sel_q;
          reg_rdata[SS_IDLE_BIT]        <= idle_q;
        end
        REG_HP_LEVEL:  reg_rdata[LEVEL_W-1:0] <= hp_q;
        default:       reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

  // Level of whatever the encoder currently drives.
  logic [LEVEL_W-1:0] sel_level;
  always_comb begin
    case (tgt_q)
      TGT_CHANNEL:   sel_level = ch_lvl_q[mix_q][ch_sel_q];
      TGT_HEADPHONE: sel_level = hp_q;
      default:       sel_level = out_lvl_q[mix_q];
    endcase
  end

  // Indicators and meter, registered so the panel never sees decode glitches.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      led_mix_white <= '0;
      led_out_white <= 1'b0;
      led_ch_white  <= '0;
      led_ch_red    <= '0;
      led_fx_white  <= '0;
      led_hp_white  <= 1'b0;
      meter_white   <= '0;
      meter_green   <= '0;
      pair_clear    <= 1'b0;
    end else begin
      led_mix_white <= NUM_MIX'(1) << mix_q; // [R4]
      led_out_white <= (tgt_q == TGT_OUTPUT); // [R3]
      led_ch_white  <= (tgt_q == TGT_CHANNEL) ? (NUM_CH'(1) << ch_sel_q) : '0; // [R5]
      led_ch_red    <= ch_overload; // [R13]
      // Presets chosen by software beyond the front four light nothing.
      led_fx_white  <= (preset_q < 4'(NUM_FRONT_PRESET)) ?
                       (NUM_FRONT_PRESET'(1) << preset_q[1:0]) : '0; // [R7]
      led_hp_white  <= (tgt_q == TGT_HEADPHONE); // [R9]
      meter_white   <= idle_q ? '0 : bar(sel_level); // [R6]
      meter_green   <= idle_q ? bar(main_meter) : '0; // [R12]
      pair_clear    <= factory_q; // [R11]
    end
  end

  // Flatten level arrays for the audio side.
  always_comb begin
    for (int m = 0; m < NUM_MIX; m++) begin
      out_levels[m*LEVEL_W +: LEVEL_W] = out_lvl_q[m];
      for (int c = 0; c < NUM_CH; c++) begin
        ch_levels[(m*NUM_CH+c)*LEVEL_W +: LEVEL_W] = ch_lvl_q[m][c];
      end
    end
  end

  assign hp_level  = hp_q;
  assign fx_preset = preset_q;
  assign fx_return = fx_ret_q;

endmodule // front_panel_select_ctrl

/* verif/panel_select_properties.sv */
// Purpose: Timing properties of the front-panel selection controller.
// Assumes: Single clock domain; the operator presses one control at a time.
// Notes:   Idle and chord windows are counted in helper logic beside the properties.
`timescale 1ns/1ps
module panel_select_props
  import front_panel_pkg::*;
#(
  parameter int unsigned NUM_CH      = 6,
  parameter int unsigned LEVEL_W     = 8,
  parameter int unsigned INACT_COUNT = 50,
  parameter int unsigned CHORD_COUNT = 20
) (
  // Clock and reset.
  input wire logic                         clk,
  input wire logic                         arst_n,
  // Operator and audio side inputs.
  input wire front_panel_pkg::btn_t        btn,
  input wire logic [NUM_CH-1:0]            btn_ch,
  input wire front_panel_pkg::enc_t        enc,
  input wire logic [NUM_CH-1:0]            ch_overload,
  input wire logic [LEVEL_W-1:0]           main_meter,
  input wire logic                         reg_rd,
  // Design outputs.
  input wire logic [31:0]                  reg_rdata,
  input wire logic [NUM_MIX-1:0]           led_mix_white,
  input wire logic                         led_out_white,
  input wire logic [NUM_CH-1:0]            led_ch_white,
  input wire logic [NUM_CH-1:0]            led_ch_red,
  input wire logic [NUM_FRONT_PRESET-1:0]  led_fx_white,
  input wire logic                         led_hp_white,
  input wire logic [METER_SEGS-1:0]        meter_green,
  input wire logic                         pair_clear
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  localparam int SAT = INACT_COUNT + 8;
  logic [3:0]        btn_v;
  logic [3:0]        btn_q;
  logic [NUM_CH-1:0] ch_q;
  logic              act;
  logic              chord;
  int                idle_cnt_q;
  int                hold_cnt_q;
  // A press is a rising level; a held chord parks the idle count out of range.
  assign btn_v = btn;
  assign chord = btn_ch[0] & btn_ch[1] & btn.out_sel;
  assign act = (|(btn_v & ~btn_q)) | (|(btn_ch & ~ch_q)) | enc.step;
  // Counts cycles since the last activity and cycles the chord is held.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      btn_q <= '0;
      ch_q <= '0;
      idle_cnt_q <= SAT;
      hold_cnt_q <= 0;
    end else begin
      btn_q <= btn_v;
      ch_q <= btn_ch;
      hold_cnt_q <= chord ? hold_cnt_q + 1 : 0;
      if (chord) begin
        idle_cnt_q <= SAT;
      end else if (act) begin
        idle_cnt_q <= 0;
      end else if (idle_cnt_q < SAT) begin
        idle_cnt_q <= idle_cnt_q + 1;
      end
    end
  end
  a_mix_step: assert property (
    $rose(btn.mix_sel) && led_mix_white == 4'h1 |-> ##2 led_mix_white == 4'h2)
    else $error("mix select did not step from main");
  a_mix_wrap: assert property (
    $rose(btn.mix_sel) && led_mix_white == 4'h8 |-> ##2 led_mix_white == 4'h1)
    else $error("mix select did not wrap to main");
  a_out_white: assert property (
    $rose(btn.out_sel) && !btn.mix_sel |-> ##2 led_out_white)
    else $error("output indicator not lit");
  a_hp_white: assert property (
    $rose(btn.headphone) && !btn.mix_sel && !btn.out_sel && btn_ch == '0
    |-> ##2 led_hp_white && !led_out_white && led_ch_white == '0)
    else $error("headphone selection not shown");
  a_fx_step: assert property (
    $rose(btn.effect) && led_fx_white == 4'h1 |-> ##2 led_fx_white == 4'h2)
    else $error("effect preset did not step");
  a_red_follow: assert property (
    $rose(ch_overload[1]) |=> led_ch_red[1])
    else $error("overload indicator late");
  a_pair_pulse: assert property (
    pair_clear |=> !pair_clear)
    else $error("pair clear longer than one cycle");
  a_chord_time: assert property (
    pair_clear |-> hold_cnt_q >= CHORD_COUNT - 1 && hold_cnt_q <= CHORD_COUNT + 4)
    else $error("factory reset outside chord window");
  a_quiet_meter: assert property (
    idle_cnt_q >= 1 && idle_cnt_q <= INACT_COUNT - 2 |-> meter_green == '0)
    else $error("green meter while active");
  a_green_back: assert property (
    idle_cnt_q == INACT_COUNT + 3 && main_meter != '0 |-> meter_green != '0)
    else $error("green meter missing after idle");
  a_rdata_idle: assert property (
    !$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside read slot");
endmodule // panel_select_props

bind front_panel_select_ctrl panel_select_props #(
  .NUM_CH(NUM_CH), .LEVEL_W(LEVEL_W),
  .INACT_COUNT(INACT_COUNT), .CHORD_COUNT(CHORD_COUNT)
) panel_select_props_inst (
  .clk(clk), .arst_n(arst_n), .btn(btn), .btn_ch(btn_ch), .enc(enc),
  .ch_overload(ch_overload), .main_meter(main_meter), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .led_mix_white(led_mix_white), .led_out_white(led_out_white),
  .led_ch_white(led_ch_white), .led_ch_red(led_ch_red), .led_fx_white(led_fx_white),
  .led_hp_white(led_hp_white), .meter_green(meter_green), .pair_clear(pair_clear)
);

/* verif/panel_operator.sv */
// Purpose: Operator model: buttons held as levels and encoder detents.
// Assumes: Presses are spaced so every rise is seen by the panel logic.
// Notes:   Each action ends two cycles after release so indicators have settled.
`timescale 1ns/1ps
module panel_operator
  import front_panel_pkg::*;
#(
  parameter int unsigned NUM_CH = 6
) (
  // Clock.
  input  wire logic              clk,
  // Controls toward the panel.
  output front_panel_pkg::btn_t  btn,
  output logic [NUM_CH-1:0]      btn_ch,
  output front_panel_pkg::enc_t  enc
);
  // Nothing pressed at power-up.
  initial begin
    btn = '0;
    btn_ch = '0;
    enc = '0;
  end
  // Holds buttons for n cycles, then releases them for a clean next rise.
  task automatic push(input logic [3:0] b, input logic [NUM_CH-1:0] c, input int n);
    @(posedge clk);
    btn <= b;
    btn_ch <= c;
    repeat (n) @(posedge clk);
    btn <= '0;
    btn_ch <= '0;
    repeat (2) @(posedge clk);
    #1;
  endtask
  // Back-to-back detents in one direction.
  task automatic turn(input logic cw, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      enc <= {1'b1, cw};
    end
    @(posedge clk);
    enc <= '0;
    repeat (2) @(posedge clk);
    #1;
  endtask
endmodule // panel_operator

/* verif/tb.sv */
// Purpose: Self-checking bench for the front-panel selection controller.
// Assumes: Short idle and chord counts so the whole run stays brief.
// Notes:   Register reads sample data one step after the taking edge.
`timescale 1ns/1ps
module tb;
  import front_panel_pkg::*;
  localparam int unsigned IC = 50;
  localparam int unsigned CC = 20;
  logic          clk = 1'b0;
  logic          arst_n = 1'b0;
  btn_t          btn;
  enc_t          enc;
  logic [5:0]    btn_ch, led_ch_white, led_ch_red;
  logic [5:0]    ch_overload = '0;
  logic [7:0]    main_meter = 8'hFF;
  logic [7:0]    reg_addr = '0;
  logic [31:0]   reg_wdata = '0;
  logic          reg_wr = 1'b0;
  logic          reg_rd = 1'b0;
  logic [31:0]   reg_rdata, rd_v, out_levels;
  logic          irq, led_out_white, led_hp_white, pair_clear;
  logic [3:0]    led_mix_white, led_fx_white, fx_preset;
  logic [14:0]   meter_white, meter_green;
  logic [191:0]  ch_levels;
  logic [7:0]    hp_level, fx_return;
  int            error_cnt = 0;
  int            n_checks = 0;
  int            pc_cnt = 0;
  // Free-running clock.
  always #5 clk = ~clk;
  panel_operator #(.NUM_CH(6)) panel_operator_inst (
    .clk(clk), .btn(btn), .btn_ch(btn_ch), .enc(enc));
  front_panel_select_ctrl #(.NUM_CH(6), .LARGE_MODEL(1'b1), .LEVEL_W(8),
    .INACT_COUNT(IC), .CHORD_COUNT(CC)) front_panel_select_ctrl_inst (
    .clk(clk), .arst_n(arst_n), .btn(btn), .btn_ch(btn_ch), .enc(enc),
    .ch_overload(ch_overload), .main_meter(main_meter), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .irq(irq), .led_mix_white(led_mix_white), .led_out_white(led_out_white),
    .led_ch_white(led_ch_white), .led_ch_red(led_ch_red), .led_fx_white(led_fx_white),
    .led_hp_white(led_hp_white), .meter_white(meter_white), .meter_green(meter_green),
    .ch_levels(ch_levels), .out_levels(out_levels), .hp_level(hp_level),
    .fx_preset(fx_preset), .fx_return(fx_return), .pair_clear(pair_clear));
  // Counts pairing-clear pulses.
  always @(posedge clk) begin
    if (pair_clear === 1'b1) begin
      pc_cnt <= pc_cnt + 1;
    end
  end
  task automatic chk(input string nm, input logic [191:0] e, input logic [191:0] g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    rd_v = reg_rdata;
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Cuts a hang short well past the expected run of a few hundred cycles.
  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    final_report();
  end
  // Main sequence.
  initial begin
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk("mix_led", 4'h1, led_mix_white);
    chk("out_led", 1'b1, led_out_white);
    rd(REG_SEL_STATE);
    chk("sel_state", 32'h100, rd_v);
    rd(REG_MASK);
    chk("mask", 32'h0, rd_v);
    $display("test reset done");
    for (int i = 1; i < 5; i++) begin
      panel_operator_inst.push(4'h8, '0, 1);
      chk("mix_led", 4'h1 << (i % 4), led_mix_white);
    end
    panel_operator_inst.push(4'h8, '0, 1);
    panel_operator_inst.push(4'h4, '0, 1);
    chk("out_led", 1'b1, led_out_white);
    panel_operator_inst.turn(1'b1, 3);
    panel_operator_inst.turn(1'b0, 1);
    chk("send1_out", 8'h02, out_levels[15:8]);
    chk("meter_white", 15'h0001, meter_white);
    wr(REG_MASK, 32'h8);
    chk("irq_set", 1'b1, irq);
    wr(REG_STATUS, 32'h8);
    chk("irq_clr", 1'b0, irq);
    $display("test mix and output done");
    panel_operator_inst.push(4'h0, 6'h04, 1);
    chk("ch_led", 6'h04, led_ch_white);
    panel_operator_inst.turn(1'b1, 2);
    chk("ch_level", 8'h02, ch_levels[71:64]);
    panel_operator_inst.turn(1'b0, 3);
    chk("ch_floor", 8'h00, ch_levels[71:64]);
    panel_operator_inst.push(4'h1, '0, 1);
    chk("hp_led", 1'b1, led_hp_white);
    panel_operator_inst.turn(1'b1, 5);
    rd(REG_HP_LEVEL);
    chk("hp_level", 32'h5, rd_v);
    $display("test channel and phones done");
    repeat (IC + 5) @(posedge clk);
    #1;
    chk("mix_led", 4'h1, led_mix_white);
    chk("out_led", 1'b1, led_out_white);
    chk("meter_white", 15'h0, meter_white);
    chk("meter_green", 15'h7FFF, meter_green);
    rd(REG_SEL_STATE);
    chk("sel_state", 32'h100, rd_v);
    rd(REG_STATUS);
    chk("st_revert", 1'b1, rd_v[0]);
    $display("test revert done");
    for (int i = 1; i < 5; i++) begin
      panel_operator_inst.push(4'h2, '0, 1);
      chk("fx_led", 4'h1 << (i % 4), led_fx_white);
    end
    wr(REG_FX_PRESET, 32'h9);
    rd(REG_FX_PRESET);
    chk("fx_preset", 32'h9, rd_v);
    chk("fx_led", 4'h0, led_fx_white);
    wr(REG_FX_RETURN, 32'h5A);
    rd(REG_FX_RETURN);
    chk("fx_return", 32'h5A, rd_v);
    rd(8'h20);
    chk("unmapped", 32'h0, rd_v);
    $display("test effects done");
    @(posedge clk);
    ch_overload <= 6'h02;
    repeat (2) @(posedge clk);
    #1;
    chk("ch_red", 6'h02, led_ch_red);
    rd(REG_STATUS);
    chk("st_overload", 1'b1, rd_v[2]);
    @(posedge clk);
    ch_overload <= 6'h00;
    $display("test overload done");
    panel_operator_inst.push(4'h4, 6'h03, CC + 5);
    chk("pair_clear", 1, pc_cnt);
    chk("hp_level", 8'h0, hp_level);
    chk("out_levels", 32'h0, out_levels);
    chk("fx_preset", 4'h0, fx_preset);
    chk("fx_return", 8'h0, fx_return);
    rd(REG_STATUS);
    chk("st_factory", 1'b1, rd_v[1]);
    $display("test factory done");
    final_report();
  end
endmodule // tb
